/* File: verilog/cfe_defines.svh */
/*
  Constants for the channel function executor: packet fields, function
  codes, subfunction codes and segment sizes.
  Assumes it is included by bare name from files that need the constants.
*/
`ifndef CFE_DEFINES_SVH
`define CFE_DEFINES_SVH

// first parcel fields
`define CFE_ZERO_MSB   15
`define CFE_ZERO_LSB   14
`define CFE_FC_MSB     13
`define CFE_FC_LSB     9
`define CFE_ID_MSB     8
`define CFE_ID_LSB     7
`define CFE_SUB_MSB    1
`define CFE_SUB_LSB    0

// function codes (octal 10..37)
`define CFE_F_LOAD     5'h08
`define CFE_F_STORE    5'h09
`define CFE_F_RESTART  5'h0a
`define CFE_F_STOP     5'h0b
`define CFE_F_RDPC     5'h0c
`define CFE_F_ENTPC    5'h0d
`define CFE_F_RDIF     5'h0e
`define CFE_F_ENTIF    5'h0f
`define CFE_F_BLKCH    5'h10
`define CFE_F_RDREF    5'h11
`define CFE_F_RDUP     5'h12
`define CFE_F_RDLO     5'h13
`define CFE_F_BLKBUF   5'h16
`define CFE_F_BUFREF   5'h17
`define CFE_F_STCH     5'h18
`define CFE_F_STREF    5'h19
`define CFE_F_ENTUP    5'h1a
`define CFE_F_ENTLO    5'h1b
`define CFE_F_STBUF    5'h1e
`define CFE_F_ENTBUF   5'h1f

// interface register subfunctions
`define CFE_SUB_STATUS 2'h0
`define CFE_SUB_MADDR  2'h1
`define CFE_SUB_ERR    2'h2

// lengths
`define CFE_SEG_WORDS  7'h40
`define CFE_SEG_LEN10  10'h040
`define CFE_LOAD_WORDS 7'h04
`define CFE_STORE_WORDS 7'h02
`define CFE_ONE_WORD   7'h01
`define CFE_BLANK      32'h0000_0000

`endif

/* File: verilog/cfe_pkg.sv */
/*
  Types for the channel function executor.
  Assumes the constants header is compiled alongside.
*/
package cfe_pkg;
  typedef enum logic [3:0] {
    CFE_IDLE, CFE_GET, CFE_DECODE, CFE_PREP, CFE_MRD_ISS, CFE_MRD_WAIT,
    CFE_FETCH, CFE_USE, CFE_MWR_WAIT, CFE_SEND_PULSE, CFE_WAIT_DP,
    CFE_SEG_END, CFE_RECV_WAIT, CFE_RECV, CFE_RESP
  } cfe_state_e;
  typedef logic [63:0] cfe_word_t;
  typedef logic [5:0]  cfe_bptr_t;
endpackage

/* File: verilog/cfe_buf_if.sv */
/*
  Port bundle between the executor and its 64-word foreground buffer.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface cfe_buf_if;
  import cfe_pkg::*;
  logic      we;
  cfe_bptr_t waddr;
  cfe_word_t wdata;
  cfe_bptr_t raddr;
  cfe_word_t rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* File: verilog/cfe_fg_buffer.sv */
/*
  Foreground memory buffer: 64 words of 64 bits, one write port, one
  registered read port (data valid the cycle after the address).
  Assumes a single clock; contents are undefined until written.
*/
`timescale 1ns/1ps
module cfe_fg_buffer
  import cfe_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // buffer port
  cfe_buf_if.mem   bus
);
  import cfe_pkg::*;

  cfe_word_t mem_array [64];
  cfe_word_t rdata_reg;

  always_ff @(posedge mclk_i) begin
    if (bus.we) begin
      mem_array[bus.waddr] <= bus.wdata;
    end
    rdata_reg <= mem_array[bus.raddr];
  end

  assign bus.rdata = rdata_reg;
endmodule

/* File: verilog/cfe_executor.sv */
/*
  Channel function executor of a background processor interface: takes
  four-parcel function packets from the foreground channel, runs them
  against common memory, the foreground buffer and the processor registers.
  Assumes channel, memory and processor logic share mclk_i; memory answers
  each single-word request with a one-cycle mem_ack_i carrying read data.
*/
`timescale 1ns/1ps
`include "cfe_defines.svh"
module cfe_executor #(
  parameter logic [1:0] PROC_ID = 2'h0
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  // foreground channel in
  input  wire logic             ch_func_i,
  input  wire logic             ch_parcel_vld_i,
  input  wire logic [15:0]      ch_parcel_i,
  input  wire logic             ch_dpulse_i,
  input  wire logic             ch_word_vld_i,
  input  wire cfe_pkg::cfe_word_t ch_word_i,
  // foreground channel out
  output logic                  ch_resp_o,
  output logic [31:0]           ch_resp_data_o,
  output logic                  ch_dpulse_o,
  output logic                  ch_word_vld_o,
  output cfe_pkg::cfe_word_t    ch_word_o,
  // common memory
  output logic                  mem_req_o,
  output logic                  mem_we_o,
  output logic [31:0]           mem_addr_o,
  output cfe_pkg::cfe_word_t    mem_wdata_o,
  input  wire logic             mem_ack_i,
  input  wire cfe_pkg::cfe_word_t mem_rdata_i,
  // background processor
  input  wire logic [31:0]      bp_pc_i,
  output logic [31:0]           bp_pc_o,
  output logic [31:0]           bp_status_o,
  output logic [31:0]           bp_base_o,
  output logic [31:0]           limit_bound_o,
  output logic [31:0]           err_data_o,
  output logic [15:0]           call_resp_o,
  output logic                  bp_load_o,
  output logic                  bp_start_o,
  output logic                  bp_stop_o,
  output logic                  stack_inval_o
);
  import cfe_pkg::*;

  function automatic logic [6:0] seg_of(input logic [9:0] len);
    seg_of = (len >= `CFE_SEG_LEN10) ? `CFE_SEG_WORDS : len[6:0];
  endfunction

  cfe_buf_if fgb ();
  cfe_fg_buffer u_buf (
    .mclk_i (mclk_i),
    .bus    (fgb.mem)
  );

  cfe_state_e  state_reg, state_next;
  logic [15:0] p1_reg, p1_next, p2_reg, p2_next, p3_reg, p3_next, p4_reg, p4_next;
  logic [1:0]  pcnt_reg, pcnt_next;
  logic [6:0]  cnt_reg, cnt_next, seg_reg, seg_next;
  logic [9:0]  len_reg, len_next;
  logic [31:0] work_reg, work_next, maddr_reg, maddr_next;
  logic [15:0] cresp_reg, cresp_next;
  logic [31:0] pc_reg, pc_next, status_reg, status_next;
  logic [31:0] base_reg, base_next, limit_bound_reg, limit_bound_next;
  logic [31:0] err_reg, err_next, refhi_reg, refhi_next, reflo_reg, reflo_next;
  logic        resp_reg, resp_next, dpulse_reg, dpulse_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        wvld_reg, wvld_next;
  cfe_word_t   word_reg, word_next, mwdata_reg, mwdata_next;
  logic        mreq_reg, mreq_next, mwe_reg, mwe_next;
  logic [31:0] maddr_o_reg, maddr_o_next;
  logic        load_reg, load_next, start_reg, start_next;
  logic        stop_reg, stop_next, inval_reg, inval_next;

  logic [4:0]  fcode;
  logic [1:0]  subf;
  logic [31:0] p34;
  logic [6:0]  cnt_inc;
  logic        last_word;
  logic [9:0]  len_left;

  assign fcode     = p1_reg[`CFE_FC_MSB:`CFE_FC_LSB];
  assign subf      = p1_reg[`CFE_SUB_MSB:`CFE_SUB_LSB];
  assign p34       = {p3_reg, p4_reg};
  assign cnt_inc   = 7'(cnt_reg + 7'h01);
  assign last_word = (cnt_inc == seg_reg);
  assign len_left  = 10'(len_reg - `CFE_SEG_LEN10);

  always_comb begin
    logic do_resp;
    logic [31:0] rval;
    do_resp = 1'b0;
    rval    = `CFE_BLANK;
    state_next = state_reg;
    p1_next = p1_reg;
    p2_next = p2_reg;
    p3_next = p3_reg;
    p4_next = p4_reg;
    pcnt_next = pcnt_reg;
    cnt_next = cnt_reg;
    seg_next = seg_reg;
    len_next = len_reg;
    work_next = work_reg;
    maddr_next = maddr_reg;
    cresp_next = cresp_reg;
    pc_next = pc_reg;
    status_next = status_reg;
    base_next = base_reg;
    limit_bound_next = limit_bound_reg;
    err_next = err_reg;
    refhi_next = refhi_reg;
    reflo_next = reflo_reg;
    rdata_next = rdata_reg;
    word_next = word_reg;
    mwdata_next = mwdata_reg;
    mreq_next = mreq_reg;
    mwe_next = mwe_reg;
    maddr_o_next = maddr_o_reg;
    resp_next = 1'b0;
    dpulse_next = 1'b0;
    wvld_next = 1'b0;
    load_next = 1'b0;
    start_next = 1'b0;
    stop_next = 1'b0;
    inval_next = 1'b0;
    fgb.we    = 1'b0;
    fgb.waddr = cnt_reg[5:0];
    fgb.wdata = ch_word_i;
    fgb.raddr = (fcode == `CFE_F_BUFREF) ? p2_reg[5:0] : cnt_reg[5:0];

    unique case (state_reg)
      CFE_IDLE: begin
        if (ch_func_i && ch_parcel_i[`CFE_ZERO_MSB:`CFE_ZERO_LSB] == 2'h0 &&
            ch_parcel_i[`CFE_ID_MSB:`CFE_ID_LSB] == PROC_ID) begin
          p1_next    = ch_parcel_i;
          pcnt_next  = 2'h0;
          state_next = CFE_GET;
        end
      end
      CFE_GET: begin
        if (ch_parcel_vld_i) begin
          unique case (pcnt_reg)
            2'h0: p2_next = ch_parcel_i;
            2'h1: p3_next = ch_parcel_i;
            default: p4_next = ch_parcel_i;
          endcase
          pcnt_next = 2'(pcnt_reg + 2'h1);
          if (pcnt_reg == 2'h2) begin
            state_next = CFE_DECODE;
          end
        end
      end
      CFE_DECODE: begin
        cnt_next  = 7'h00;
        work_next = p34;
        unique case (fcode)
          `CFE_F_LOAD: begin
            cresp_next = p2_reg;
            maddr_next = p34;
            len_next   = {3'h0, `CFE_LOAD_WORDS};
            seg_next   = `CFE_LOAD_WORDS;
            state_next = CFE_MRD_ISS;
          end
          `CFE_F_STORE: begin
            maddr_next = p34;
            len_next   = {3'h0, `CFE_STORE_WORDS};
            seg_next   = `CFE_STORE_WORDS;
            state_next = CFE_PREP;
          end
          `CFE_F_RESTART: begin
            cresp_next = p2_reg;
            start_next = 1'b1;
            do_resp    = 1'b1;
          end
          `CFE_F_STOP: begin
            stop_next = 1'b1;
            do_resp   = 1'b1;
          end
          `CFE_F_RDPC: begin
            rval    = bp_pc_i;
            do_resp = 1'b1;
          end
          `CFE_F_ENTPC: begin
            pc_next   = p34;
            load_next = 1'b1;
            do_resp   = 1'b1;
          end
          `CFE_F_RDIF: begin
            unique case (subf)
              `CFE_SUB_STATUS: rval = status_reg;
              `CFE_SUB_MADDR:  rval = maddr_reg;
              `CFE_SUB_ERR:    rval = err_reg;
              default:         rval = `CFE_BLANK;
            endcase
            do_resp = 1'b1;
          end
          `CFE_F_ENTIF: begin
            cresp_next = p2_reg;
            unique case (subf)
              `CFE_SUB_STATUS: status_next = p34;
              `CFE_SUB_MADDR:  maddr_next = p34;
              `CFE_SUB_ERR:    err_next = p34;
              default:         err_next = err_reg;
            endcase
            do_resp = 1'b1;
          end
          `CFE_F_BLKCH, `CFE_F_STCH: begin
            len_next   = p2_reg[9:0];
            maddr_next = p34;
            seg_next   = seg_of(p2_reg[9:0]);
            if (fcode == `CFE_F_STCH) begin
              resp_next  = 1'b1;
              rdata_next = `CFE_BLANK;
              state_next = (p2_reg[9:0] == 10'h000) ? CFE_IDLE : CFE_RECV_WAIT;
            end else begin
              state_next = (p2_reg[9:0] == 10'h000) ? CFE_RESP : CFE_MRD_ISS;
            end
          end
          `CFE_F_RDREF: begin
            maddr_next = p34;
            len_next   = {3'h0, `CFE_ONE_WORD};
            seg_next   = `CFE_ONE_WORD;
            state_next = CFE_MRD_ISS;
          end
          `CFE_F_RDUP: begin
            rval    = refhi_reg;
            do_resp = 1'b1;
          end
          `CFE_F_RDLO: begin
            rval    = reflo_reg;
            do_resp = 1'b1;
          end
          `CFE_F_BLKBUF, `CFE_F_STBUF: begin
            len_next   = {3'h0, p2_reg[6:0]};
            maddr_next = p34;
            seg_next   = seg_of({3'h0, p2_reg[6:0]});
            if (p2_reg[6:0] == 7'h00) begin
              state_next = CFE_RESP;
            end else begin
              state_next = (fcode == `CFE_F_BLKBUF) ? CFE_MRD_ISS : CFE_FETCH;
            end
          end
          `CFE_F_BUFREF: state_next = CFE_FETCH;
          `CFE_F_STREF: begin
            maddr_next = p34;
            len_next   = {3'h0, `CFE_ONE_WORD};
            seg_next   = `CFE_ONE_WORD;
            state_next = CFE_PREP;
          end
          `CFE_F_ENTUP: begin
            refhi_next = p34;
            do_resp    = 1'b1;
          end
          `CFE_F_ENTLO: begin
            reflo_next = p34;
            do_resp    = 1'b1;
          end
          `CFE_F_ENTBUF: begin
            fgb.we    = 1'b1;
            fgb.waddr = p2_reg[5:0];
            fgb.wdata = {refhi_reg, reflo_reg};
            do_resp   = 1'b1;
          end
          default: do_resp = 1'b1;
        endcase
      end
      CFE_PREP: begin
        fgb.we = 1'b1;
        if (fcode == `CFE_F_STREF) begin
          fgb.wdata = {refhi_reg, reflo_reg};
        end else if (cnt_reg == 7'h00) begin
          fgb.wdata = {32'h0000_0000, bp_pc_i};
        end else begin
          fgb.wdata = {32'h0000_0000, status_reg};
        end
        cnt_next = cnt_inc;
        if (last_word) begin
          cnt_next   = 7'h00;
          state_next = CFE_FETCH;
        end
      end
      CFE_MRD_ISS: begin
        mreq_next    = 1'b1;
        mwe_next     = 1'b0;
        maddr_o_next = 32'(work_reg + {25'h0, cnt_reg});
        state_next   = CFE_MRD_WAIT;
      end
      CFE_MRD_WAIT: begin
        if (mem_ack_i) begin
          mreq_next = 1'b0;
          fgb.we    = 1'b1;
          fgb.wdata = mem_rdata_i;
          cnt_next  = cnt_inc;
          if (last_word) begin
            cnt_next = 7'h00;
            unique case (fcode)
              `CFE_F_LOAD, `CFE_F_RDREF: state_next = CFE_FETCH;
              `CFE_F_BLKCH:              state_next = CFE_SEND_PULSE;
              default:                   state_next = CFE_RESP;
            endcase
          end else begin
            state_next = CFE_MRD_ISS;
          end
        end
      end
      CFE_FETCH: state_next = CFE_USE;
      CFE_USE: begin
        unique case (fcode)
          `CFE_F_LOAD: begin
            unique case (cnt_reg[1:0])
              2'h0: pc_next = fgb.rdata[31:0];
              2'h1: status_next = fgb.rdata[31:0];
              2'h2: base_next = fgb.rdata[31:0];
              default: limit_bound_next = fgb.rdata[31:0];
            endcase
            cnt_next = cnt_inc;
            if (last_word) begin
              load_next  = 1'b1;
              start_next = 1'b1;
              inval_next = 1'b1;
              state_next = CFE_RESP;
            end else begin
              state_next = CFE_FETCH;
            end
          end
          `CFE_F_RDREF, `CFE_F_BUFREF: begin
            refhi_next = fgb.rdata[63:32];
            reflo_next = fgb.rdata[31:0];
            state_next = CFE_RESP;
          end
          `CFE_F_BLKCH: begin
            word_next  = fgb.rdata;
            wvld_next  = 1'b1;
            cnt_next   = cnt_inc;
            state_next = last_word ? CFE_WAIT_DP : CFE_FETCH;
          end
          default: begin
            mreq_next    = 1'b1;
            mwe_next     = 1'b1;
            maddr_o_next = 32'(work_reg + {25'h0, cnt_reg});
            mwdata_next  = fgb.rdata;
            state_next   = CFE_MWR_WAIT;
          end
        endcase
      end
      CFE_MWR_WAIT: begin
        if (mem_ack_i) begin
          mreq_next = 1'b0;
          mwe_next  = 1'b0;
          cnt_next  = cnt_inc;
          if (!last_word) begin
            state_next = CFE_FETCH;
          end else if (fcode == `CFE_F_STCH) begin
            dpulse_next = 1'b1;
            state_next  = CFE_SEG_END;
          end else begin
            state_next = CFE_RESP;
          end
        end
      end
      CFE_SEND_PULSE: begin
        dpulse_next = 1'b1;
        cnt_next    = 7'h00;
        state_next  = CFE_FETCH;
      end
      CFE_WAIT_DP: begin
        if (ch_dpulse_i) begin
          state_next = CFE_SEG_END;
        end
      end
      CFE_SEG_END: begin
        cnt_next = 7'h00;
        if (seg_reg != `CFE_SEG_WORDS || len_left == 10'h000) begin
          if (seg_reg == `CFE_SEG_WORDS) begin
            len_next = len_left;
          end
          state_next = (fcode == `CFE_F_BLKCH) ? CFE_RESP : CFE_IDLE;
        end else begin
          len_next   = len_left;
          work_next  = 32'(work_reg + {25'h0, `CFE_SEG_WORDS});
          seg_next   = seg_of(len_left);
          state_next = (fcode == `CFE_F_BLKCH) ? CFE_MRD_ISS : CFE_RECV_WAIT;
        end
      end
      CFE_RECV_WAIT: begin
        if (ch_dpulse_i) begin
          cnt_next   = 7'h00;
          state_next = CFE_RECV;
        end
      end
      CFE_RECV: begin
        if (ch_word_vld_i) begin
          fgb.we   = 1'b1;
          cnt_next = cnt_inc;
          if (last_word) begin
            cnt_next   = 7'h00;
            state_next = CFE_FETCH;
          end
        end
      end
      CFE_RESP: begin
        do_resp = 1'b1;
      end
    endcase

    if (do_resp) begin
      resp_next  = 1'b1;
      rdata_next = rval;
      state_next = CFE_IDLE;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= CFE_IDLE;
      p1_reg <= 16'h0000;
      p2_reg <= 16'h0000;
      p3_reg <= 16'h0000;
      p4_reg <= 16'h0000;
      pcnt_reg <= 2'h0;
      cnt_reg <= 7'h00;
      seg_reg <= 7'h00;
      len_reg <= 10'h000;
      work_reg <= 32'h0;
      maddr_reg <= 32'h0;
      cresp_reg <= 16'h0000;
      pc_reg <= 32'h0;
      status_reg <= 32'h0;
      base_reg <= 32'h0;
      limit_bound_reg <= 32'h0;
      err_reg <= 32'h0;
      refhi_reg <= 32'h0;
      reflo_reg <= 32'h0;
      resp_reg <= 1'b0;
      rdata_reg <= 32'h0;
      dpulse_reg <= 1'b0;
      wvld_reg <= 1'b0;
      word_reg <= 64'h0;
      mwdata_reg <= 64'h0;
      mreq_reg <= 1'b0;
      mwe_reg <= 1'b0;
      maddr_o_reg <= 32'h0;
      load_reg <= 1'b0;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
      inval_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      p1_reg <= p1_next;
      p2_reg <= p2_next;
      p3_reg <= p3_next;
      p4_reg <= p4_next;
      pcnt_reg <= pcnt_next;
      cnt_reg <= cnt_next;
      seg_reg <= seg_next;
      len_reg <= len_next;
      work_reg <= work_next;
      maddr_reg <= maddr_next;
      cresp_reg <= cresp_next;
      pc_reg <= pc_next;
      status_reg <= status_next;
      base_reg <= base_next;
      limit_bound_reg <= limit_bound_next;
      err_reg <= err_next;
      refhi_reg <= refhi_next;
      reflo_reg <= reflo_next;
      resp_reg <= resp_next;
      rdata_reg <= rdata_next;
      dpulse_reg <= dpulse_next;
      wvld_reg <= wvld_next;
      word_reg <= word_next;
      mwdata_reg <= mwdata_next;
      mreq_reg <= mreq_next;
      mwe_reg <= mwe_next;
      maddr_o_reg <= maddr_o_next;
      load_reg <= load_next;
      start_reg <= start_next;
      stop_reg <= stop_next;
      inval_reg <= inval_next;
    end
  end

  assign ch_resp_o      = resp_reg;
  assign ch_resp_data_o = rdata_reg;
  assign ch_dpulse_o    = dpulse_reg;
  assign ch_word_vld_o  = wvld_reg;
  assign ch_word_o      = word_reg;
  assign mem_req_o      = mreq_reg;
  assign mem_we_o       = mwe_reg;
  assign mem_addr_o     = maddr_o_reg;
  assign mem_wdata_o    = mwdata_reg;
  assign bp_pc_o        = pc_reg;
  assign bp_status_o    = status_reg;
  assign bp_base_o      = base_reg;
  assign limit_bound_o  = limit_bound_reg;
  assign err_data_o     = err_reg;
  assign call_resp_o    = cresp_reg;
  assign bp_load_o      = load_reg;
  assign bp_start_o     = start_reg;
  assign bp_stop_o      = stop_reg;
  assign stack_inval_o  = inval_reg;
endmodule

/* File: tb/cfe_monitor.sv */
/* checker on the executor ports
   assumes one clock, async active-low reset */
`timescale 1ns/1ps
module cfe_monitor (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ch_resp_o,
  input wire logic [31:0] ch_resp_data_o,
  input wire logic ch_dpulse_o,
  input wire logic ch_word_vld_o,
  input wire logic mem_req_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic bp_load_o,
  input wire logic bp_start_o,
  input wire logic bp_stop_o,
  input wire logic stack_inval_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rp; ch_resp_o |=> !ch_resp_o; endproperty
  a_rp: assert property (p_rp) else $error("resp long");
  property p_dp; ch_dpulse_o |=> !ch_dpulse_o; endproperty
  a_dp: assert property (p_dp) else $error("dpulse long");
  property p_wg; ch_word_vld_o |=> !ch_word_vld_o; endproperty
  a_wg: assert property (p_wg) else $error("word gap");
  property p_rh; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o); endproperty
  a_rh: assert property (p_rh) else $error("req dropped");
  property p_rd; mem_ack_i |=> !mem_req_o; endproperty
  a_rd: assert property (p_rd) else $error("req kept");
  property p_li; bp_load_o && bp_start_o |-> stack_inval_o; endproperty
  a_li: assert property (p_li) else $error("no inval");
  property p_lr; bp_start_o && stack_inval_o |=> ch_resp_o && ch_resp_data_o == 32'h0; endproperty
  a_lr: assert property (p_lr) else $error("load resp");
  property p_rs; bp_start_o && !stack_inval_o |-> ch_resp_o && ch_resp_data_o == 32'h0; endproperty
  a_rs: assert property (p_rs) else $error("restart resp");
  property p_sr; bp_stop_o |-> ##[0:4] (ch_resp_o && ch_resp_data_o == 32'h0); endproperty
  a_sr: assert property (p_sr) else $error("stop resp");
  c_ld: cover property (bp_load_o && bp_start_o);
  c_st: cover property (bp_stop_o);
  c_wd: cover property (ch_dpulse_o ##[1:8] ch_word_vld_o);
endmodule
bind cfe_executor cfe_monitor mon_u (.*);

/* File: tb/cfe_mem_model.sv */
/* common memory partner: acks each request, fast or slow
   assumes request held until ack */
`timescale 1ns/1ps
module cfe_mem_model (
  input  wire logic mclk_i,
  input  wire logic slow_i,
  input  wire logic mem_req_o,
  input  wire logic mem_we_o,
  input  wire logic [31:0] mem_addr_o,
  input  wire cfe_pkg::cfe_word_t mem_wdata_o,
  output cfe_pkg::cfe_word_t mem_rdata_i = 64'h0,
  output logic mem_ack_i = 1'b0
);
  cfe_pkg::cfe_word_t store [logic [31:0]];
  int dly = 0;
  always @(posedge mclk_i) begin
    mem_ack_i <= 1'b0;
    mem_rdata_i <= ~mem_rdata_i;
    if (mem_req_o && !mem_ack_i) begin
      dly <= dly + 1;
      if (dly >= (slow_i ? 3 : 0)) begin
        dly <= 0;
        mem_ack_i <= 1'b1;
        if (mem_we_o) store[mem_addr_o] = mem_wdata_o;
        else mem_rdata_i <= store.exists(mem_addr_o) ? store[mem_addr_o]
                            : {~mem_addr_o, mem_addr_o ^ 32'h5a5a_0000};
      end
    end
  end
endmodule

/* File: tb/test_channel_function_executor.sv */
/* self-checking bench for the executor
   assumes the monitor binds; the memory partner is instantiated here */
`timescale 1ns/1ps
`include "cfe_defines.svh"
module test_channel_function_executor;
  import cfe_pkg::*;
  localparam logic [1:0] PID = 2'h2;
  logic mclk_i = 0, rst_n_i = 0, ch_func_i = 0, ch_parcel_vld_i = 0, ch_dpulse_i = 0;
  logic ch_word_vld_i = 0, slow_i = 0, ch_resp_o, ch_dpulse_o, ch_word_vld_o, mem_req_o;
  logic mem_we_o, mem_ack_i, bp_load_o, bp_start_o, bp_stop_o, stack_inval_o, tx_dp = 0;
  logic [15:0] ch_parcel_i = 0, call_resp_o;
  logic [31:0] bp_pc_i = 0, ch_resp_data_o, mem_addr_o, bp_pc_o, bp_status_o, bp_base_o;
  logic [31:0] limit_bound_o, err_data_o, v;
  cfe_word_t ch_word_i = 0, ch_word_o, mem_wdata_o, mem_rdata_i, got_q[$], sent_q[$];
  int seed = 32'h367b912d, mismatches = 0, check_count = 0, cycles = 0, quiet = 0, n = 0;
  cfe_executor #(.PROC_ID(PID)) dut_u (.*);
  cfe_mem_model mem_u (.*);
  initial forever #25 mclk_i = ~mclk_i;
  function automatic logic [31:0] lo(input logic [31:0] a);
    return a ^ 32'h5a5a_0000;
  endfunction
  function automatic logic [15:0] pk(input logic [4:0] fc, input logic [1:0] sub);
    return {2'h0, fc, PID, 5'h00, sub};
  endfunction
  task automatic check(input logic [63:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // receiving node: answers a segment once the words stop
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (ch_word_vld_o) got_q.push_back(ch_word_o);
    quiet <= (ch_dpulse_o || ch_word_vld_o) ? 1 : (quiet == 0 || quiet == 8) ? 0 : quiet + 1;
    ch_dpulse_i <= quiet == 8 || tx_dp;
    if (cycles == 40000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic fn(input logic [15:0] p1, p2, input logic [31:0] val, input logic want,
                    input logic [31:0] exp);
    int n = 0;
    @(posedge mclk_i);
    ch_func_i <= 1;
    ch_parcel_i <= p1;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_i);
      ch_func_i <= 0;
      ch_parcel_vld_i <= 1;
      ch_parcel_i <= i == 0 ? p2 : i == 1 ? val[31:16] : val[15:0];
    end
    @(posedge mclk_i);
    ch_parcel_vld_i <= 0;
    do @(negedge mclk_i); while (!ch_resp_o && ++n < (want ? 5000 : 20));
    check(ch_resp_o, want);
    if (want) check(ch_resp_data_o, exp);
  endtask
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1;
    v = $random(seed);
    fn(pk(`CFE_F_ENTPC, 0), 0, v, 1, 0);
    check(bp_pc_o, v);
    @(posedge mclk_i) bp_pc_i <= ~v;
    fn(pk(`CFE_F_RDPC, 0), 0, 0, 1, ~v);
    fn(pk(`CFE_F_RDPC, 0) ^ 16'h0180, 0, 0, 0, 0);
    fn(pk(`CFE_F_RDPC, 0) | 16'h4000, 0, 0, 0, 0);
    for (int s = 0; s < 4; s++) begin
      v = $random(seed);
      fn(pk(`CFE_F_ENTIF, 2'(s)), 16'(256 + s), v, 1, 0);
      check(call_resp_o, 256 + s);
      if (s == 2) check(err_data_o, v);
      fn(pk(`CFE_F_RDIF, 2'(s)), 0, 0, 1, s == 3 ? 0 : v);
    end
    $display("pc and interface tests done");
    fn(pk(`CFE_F_STOP, 0), 0, 0, 1, 0);
    slow_i <= 1;
    fn(pk(`CFE_F_LOAD, 0), 16'h0abc, 32'h100, 1, 0);
    check(call_resp_o, 16'h0abc);
    check({bp_pc_o, bp_status_o}, {lo(32'h100), lo(32'h101)});
    check({bp_base_o, limit_bound_o}, {lo(32'h102), lo(32'h103)});
    @(posedge mclk_i) bp_pc_i <= v;
    fn(pk(`CFE_F_STORE, 0), 0, 32'h200, 1, 0);
    check(mem_u.store[32'h200], {32'h0, v});
    check(mem_u.store[32'h201], {32'h0, lo(32'h101)});
    fn(pk(`CFE_F_RESTART, 0), 16'h0077, 0, 1, 0);
    check(call_resp_o, 16'h0077);
    slow_i <= 0;
    $display("processor tests done");
    fn(pk(`CFE_F_RDREF, 0), 0, 32'h300, 1, 0);
    fn(pk(`CFE_F_RDUP, 0), 0, 0, 1, ~32'h300);
    fn(pk(`CFE_F_RDLO, 0), 0, 0, 1, lo(32'h300));
    fn(pk(`CFE_F_BLKBUF, 0), 3, 32'h400, 1, 0);
    fn(pk(`CFE_F_BUFREF, 0), 2, 0, 1, 0);
    fn(pk(`CFE_F_RDUP, 0), 0, 0, 1, ~32'h402);
    fn(pk(`CFE_F_BLKCH, 0), 65, 32'h500, 1, 0);
    check(got_q.size(), 65);
    foreach (got_q[i]) check(got_q[i], {~(32'h500 + i), lo(32'h500 + i)});
    v = $random(seed);
    fn(pk(`CFE_F_ENTUP, 0), 0, v, 1, 0);
    fn(pk(`CFE_F_ENTLO, 0), 0, ~v, 1, 0);
    fn(pk(`CFE_F_RDLO, 0), 0, 0, 1, ~v);
    fn(pk(`CFE_F_ENTBUF, 0), 5, 0, 1, 0);
    fn(pk(`CFE_F_STBUF, 0), 6, 32'h700, 1, 0);
    check(mem_u.store[32'h705], {v, ~v});
    check(mem_u.store[32'h700], {~32'h540, lo(32'h540)});
    fn(pk(`CFE_F_STREF, 0), 0, 32'h800, 1, 0);
    check(mem_u.store[32'h800], {v, ~v});
    $display("memory tests done");
    fn(pk(`CFE_F_STCH, 0), 3, 32'h600, 1, 0);
    @(posedge mclk_i) tx_dp <= 1;
    @(posedge mclk_i) tx_dp <= 0;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_i);
      sent_q.push_back({$random(seed), $random(seed)});
      ch_word_vld_i <= 1;
      ch_word_i <= sent_q[i];
    end
    @(posedge mclk_i) ch_word_vld_i <= 0;
    do @(negedge mclk_i); while (!ch_dpulse_o && ++n < 100);
    check(ch_dpulse_o, 1);
    foreach (sent_q[i]) check(mem_u.store[32'h600 + i], sent_q[i]);
    $display("store block test done");
    final_report();
  end
endmodule
